//--- logic/ecp_port.sv
// Extended capabilities parallel port engine with shared byte FIFO.
`timescale 1ns/1ps
`default_nettype none
module ecp_port
   import ecp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int AW    = FIFO_AW
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   input  wire logic [10:0] host_addr,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata,
   output logic             host_rd_cmd,
   output logic             host_rd_valid,
   input  wire logic        ecr_wr,
   input  wire logic [7:0]  ecr_wdata,
   output logic      [7:0]  ecr_rdata,
   input  wire logic        dir_wr,
   input  wire logic        dir_wdata,
   output logic             direction,
   output logic      [7:0]  status_rdata,
   input  wire logic [7:0]  sw_data,
   input  wire logic        sw_strobe,
   input  wire logic        sw_autofd,
   input  wire logic        sw_init,
   input  wire logic        sw_selectin,
   input  wire logic [3:0]  fifo_threshold,
   output logic             dma_request_pin,
   input  wire logic        dma_ack,
   input  wire logic        dma_tc,
   input  wire logic [7:0]  dma_wdata,
   output logic             irq,
   output logic             strobe_n,
   output logic             autofeed_n,
   output logic             reverse_request_n,
   output logic             select_in_n,
   input  wire logic        ack_n,
   input  wire logic        busy,
   input  wire logic        ack_reverse_n,
   input  wire logic        online,
   input  wire logic        fault_n,
   input  wire logic [7:0]  pd_in,
   output logic      [7:0]  pd_out,
   output logic             pd_oe_n,
   input  wire logic        external_floppy_mode,
   input  wire logic        motor_b_n_in,
   input  wire logic        drive_select_b_n_in,
   input  wire logic [4:0]  fdc_status_in,
   output logic             motor_b_output,
   output logic             drive_select_b_output,
   output logic      [4:0]  fdc_status_out
);
   // Modes in which the FIFO holds data at all.
   function automatic logic fifo_mode(input logic [2:0] m);
      return m == MODE_COMPAT_FIFO_PORT || m == MODE_ECP || m == MODE_TEST;
   endfunction

   // Modes from which any other mode may be entered.
   function automatic logic base_mode(input logic [2:0] m);
      return m == MODE_STD || m == MODE_PS2;
   endfunction

   logic [12:0]      sync1;
   logic [12:0]      sync2;
   logic             fault_d;
   logic [2:0]       mode;
   logic             nerr_dis;
   logic             dma_en;
   logic             serv;
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [FIFO_W-1:0] mem_q;
   ecp_fwd_t         fwd_state;
   ecp_rev_t         rev_state;
   logic [7:0]       fwd_data;
   logic             fwd_ack;
   logic             fwd_strobe;
   logic             rev_ack_n;
   logic [7:0]       pd_s;
   logic             ack_n_s;
   logic             busy_s;
   logic             ackrev_s;
   logic             online_s;
   logic             fault_s;
   logic             full;
   logic             empty;
   logic             fwd_run;
   logic             rev_run;
   logic             host_push;
   logic             dma_push;
   logic             rev_push;
   logic             push;
   logic [FIFO_W-1:0] push_data;
   logic             fwd_pop;
   logic             rd_pop;
   logic             pop;
   logic [AW-1:0]    next_rd_ptr;
   logic             serv_evt;
   logic             err_evt;
   logic             drive_ok;

   // Every parallel cable input passes two flops before any logic sees it.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sync1   <= PIN_SYNC_RST;
         sync2   <= PIN_SYNC_RST;
         fault_d <= 1'b1;
      end else begin
         sync1   <= {pd_in, ack_n, busy, ack_reverse_n, online, fault_n};
         sync2   <= sync1;
         fault_d <= sync2[0];
      end
   end
   assign {pd_s, ack_n_s, busy_s, ackrev_s, online_s, fault_s} = sync2;

   assign full  = count == (AW+1)'(DEPTH);
   assign empty = count == '0;
   // Handshake runs only in data-transfer modes, never in base modes.
   assign fwd_run = (mode == MODE_COMPAT_FIFO_PORT && !direction) ||
                    (mode == MODE_ECP && !direction && ackrev_s);
   assign rev_run = mode == MODE_ECP && direction && !ackrev_s;

   // Extended control: mode, error mask and DMA enable.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mode     <= ECR_RST_MODE;
         nerr_dis <= 1'b0;
         dma_en   <= 1'b0;
      end else if (ecr_wr) begin
         nerr_dis <= ecr_wdata[ECR_NERR];
         dma_en   <= ecr_wdata[ECR_DMA];
         if (base_mode(mode) ||
             base_mode(ecr_wdata[7:ECR_MODE_LO])) begin
            mode <= ecr_wdata[7:ECR_MODE_LO];
         end
      end
   end

   // Direction may only move in the bidirectional base mode.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         direction <= 1'b0;
      end else if (dir_wr && mode == MODE_PS2) begin
         direction <= dir_wdata;
      end
   end

   // FIFO writers: reverse capture never overlaps host ports or DMA
   // in direction, and a simple priority puts host ports over DMA.
   assign host_push = host_wr && !full && !direction &&
                      ((fifo_mode(mode) && host_addr == OFF_DATA_FIFO) ||
                       (mode == MODE_ECP &&
                        host_addr == OFF_ADDR_FIFO));
   assign dma_push  = dma_ack && !host_push && !full && !direction &&
                      fifo_mode(mode);
   assign rev_push  = rev_run && rev_state == REV_READY && !ack_n_s &&
                      !full;
   assign push = host_push || dma_push || rev_push;
   // Bit 8 tags a command; address port bytes become commands.
   always_comb begin
      if (rev_push) begin
         push_data = {!busy_s, pd_s};
      end else if (host_push) begin
         push_data = {host_addr == OFF_ADDR_FIFO, host_wdata};
      end else begin
         push_data = {1'b0, dma_wdata};
      end
   end

   assign fwd_pop = fwd_state == FWD_STROBE && busy_s && fwd_run;
   assign rd_pop  = !empty && (mode == MODE_TEST || rev_run) &&
                    ((host_rd && host_addr == OFF_DATA_FIFO) ||
                     (dma_ack && direction));
   assign pop = fwd_pop || rd_pop;
   assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

   // Pointers; the FIFO is cleared by reset and in base modes.
   always_ff @(posedge core_clk) begin
      if (!resetn || !fifo_mode(mode)) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   ecp_fifo_mem #(
      .WIDTH (FIFO_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .core_clk (core_clk),
      .we       (push),
      .waddr    (wr_ptr),
      .wdata    (push_data),
      .raddr    (next_rd_ptr),
      .rdata    (mem_q)
   );

   // Read data for host and DMA; one-cycle valid pulse.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         host_rdata    <= 8'h00;
         host_rd_cmd   <= 1'b0;
         host_rd_valid <= 1'b0;
      end else begin
         host_rd_valid <= rd_pop;
         if (rd_pop) begin
            host_rdata  <= mem_q[7:0];
            host_rd_cmd <= mem_q[8];
         end
      end
   end

   // Forward handshake: present byte and tag, drop strobe, wait for
   // Busy high, raise strobe, then wait for Busy to fall again.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         fwd_state  <= FWD_IDLE;
         fwd_data   <= 8'h00;
         fwd_ack    <= 1'b1;
         fwd_strobe <= 1'b0;
      end else if (!fwd_run) begin
         fwd_state  <= FWD_IDLE;
         fwd_strobe <= 1'b0;
      end else begin
         case (fwd_state)
            FWD_IDLE: begin
               if (!empty && !busy_s) begin
                  fwd_data  <= mem_q[7:0];
                  fwd_ack   <= !mem_q[8];
                  fwd_state <= FWD_SETUP;
               end
            end
            FWD_SETUP: begin
               fwd_strobe <= 1'b1;
               fwd_state  <= FWD_STROBE;
            end
            FWD_STROBE: begin
               if (busy_s) begin
                  fwd_strobe <= 1'b0;
                  fwd_state  <= FWD_HOLD;
               end
            end
            FWD_HOLD: begin
               if (!busy_s) begin
                  fwd_state <= FWD_IDLE;
               end
            end
            default: fwd_state <= FWD_IDLE;
         endcase
      end
   end

   // Reverse handshake: autofeed low means ready; capture on nAck
   // low, raise autofeed, wait for nAck to return high.
   always_ff @(posedge core_clk) begin
      if (!resetn || !rev_run) begin
         rev_state <= REV_READY;
         rev_ack_n <= 1'b0;
      end else begin
         case (rev_state)
            REV_READY: begin
               if (rev_push) begin
                  rev_ack_n <= 1'b1;
                  rev_state <= REV_RELEASE;
               end
            end
            REV_RELEASE: begin
               if (ack_n_s) begin
                  rev_ack_n <= 1'b0;
                  rev_state <= REV_READY;
               end
            end
            default: rev_state <= REV_READY;
         endcase
      end
   end

   // Outside floppy mode data lines are driven forward or in modes 000/010, and in ECP mode only while
   // the peripheral holds nAckReverse high.
   assign drive_ok = !external_floppy_mode &&
                     (mode == MODE_STD || mode == MODE_COMPAT_FIFO_PORT ||
                      !direction) &&
                     (mode != MODE_ECP || ackrev_s);

   // Pin register; ECP mode owns the lines, mode 010 strobe and data only;
   // the rest follow the software control bits.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         strobe_n          <= 1'b1;
         autofeed_n        <= 1'b1;
         reverse_request_n <= 1'b1;
         select_in_n       <= 1'b1;
         pd_out            <= 8'h00;
         pd_oe_n           <= 1'b1;
      end else begin
         pd_oe_n <= !drive_ok;
         if (mode == MODE_ECP) begin
            strobe_n          <= !fwd_strobe;
            autofeed_n        <= direction ? rev_ack_n : fwd_ack;
            reverse_request_n <= !direction;
            select_in_n       <= 1'b1;
            pd_out            <= fwd_data;
         end else begin
            strobe_n          <= mode == MODE_COMPAT_FIFO_PORT ? !fwd_strobe
                                                    : !sw_strobe;
            autofeed_n        <= !sw_autofd;
            reverse_request_n <= sw_init;
            select_in_n       <= !sw_selectin;
            pd_out            <= mode == MODE_COMPAT_FIFO_PORT ? fwd_data : sw_data;
         end
      end
   end

   // Service event: terminal count under DMA, threshold otherwise.
   always_comb begin
      if (!fifo_mode(mode)) begin
         serv_evt = 1'b0;
      end else if (dma_en) begin
         serv_evt = dma_tc;
      end else if (!direction) begin
         serv_evt = (AW+1)'(DEPTH) - count >=
                    (AW+1)'(fifo_threshold);
      end else begin
         serv_evt = count >= (AW+1)'(fifo_threshold);
      end
   end
   assign err_evt = mode == MODE_ECP && !direction && !nerr_dis &&
                    fault_d && !fault_s;

   // Service flag: hardware set wins over a software clear; a one
   // written by software sets it without an interrupt.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         serv <= 1'b0;
         irq  <= 1'b0;
      end else begin
         serv <= serv_evt || (ecr_wr ? ecr_wdata[ECR_SERV] : serv);
         irq  <= (serv_evt && !serv) || err_evt;
      end
   end

   // A pending service flag blocks further DMA requests.
   assign dma_request_pin = dma_en && !serv && fifo_mode(mode) &&
                            (direction ? !empty : !full);

   // Readback of control and port status lines.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ecr_rdata    <= 8'h00;
         status_rdata <= 8'h00;
      end else begin
         ecr_rdata    <= {mode, nerr_dis, dma_en, serv, full, empty};
         status_rdata <= {!busy_s, ack_n_s, ackrev_s, online_s, fault_s,
                          STATUS_ONES};
      end
   end

   // Floppy redirect: B lines held inactive, status ORed with pins.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         motor_b_output        <= 1'b1;
         drive_select_b_output <= 1'b1;
         fdc_status_out        <= 5'h00;
      end else if (external_floppy_mode) begin
         motor_b_output        <= 1'b1;
         drive_select_b_output <= 1'b1;
         fdc_status_out        <= fdc_status_in | pd_s[4:0];
      end else begin
         motor_b_output        <= motor_b_n_in;
         drive_select_b_output <= drive_select_b_n_in;
         fdc_status_out        <= fdc_status_in;
      end
   end

   // Checks on the handshakes and control policy.
   sequence s_fwd_strobed;
      fwd_state == FWD_STROBE && busy_s && fwd_run;
   endsequence
   sequence s_rev_take;
      rev_push && !ecr_wr;
   endsequence

   property p_mode_hold;
      @(posedge core_clk) disable iff (!resetn)
      ecr_wr && !base_mode(mode) && !base_mode(ecr_wdata[7:ECR_MODE_LO])
      |=> $stable(mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("illegal mode switch accepted");

   property p_dir_lock;
      @(posedge core_clk) disable iff (!resetn)
      $changed(direction) |-> $past(mode) == MODE_PS2;
   endproperty
   a_dir_lock: assert property (p_dir_lock)
      else $error("direction changed outside mode 001");

   property p_selin;
      @(posedge core_clk) disable iff (!resetn)
      mode == MODE_ECP && $past(mode) == MODE_ECP
      |-> select_in_n && reverse_request_n == !$past(direction);
   endproperty
   a_selin: assert property (p_selin)
      else $error("ECP control pins wrong");

   property p_fifo_off;
      @(posedge core_clk) disable iff (!resetn)
      !fifo_mode(mode) |=> empty;
   endproperty
   a_fifo_off: assert property (p_fifo_off)
      else $error("FIFO holds data in a base mode");

   property p_fwd_release;
      @(posedge core_clk) disable iff (!resetn)
      s_fwd_strobed |=> fwd_state == FWD_HOLD && !strobe_n ##1 strobe_n;
   endproperty
   a_fwd_release: assert property (p_fwd_release)
      else $error("strobe not released after Busy");

   property p_tag;
      @(posedge core_clk) disable iff (!resetn)
      $fell(strobe_n) && mode == MODE_ECP |-> autofeed_n == fwd_ack;
   endproperty
   a_tag: assert property (p_tag)
      else $error("HostAck does not match byte tag");

   property p_rev_ack;
      @(posedge core_clk) disable iff (!resetn)
      s_rev_take ##1 rev_run |=> autofeed_n;
   endproperty
   a_rev_ack: assert property (p_rev_ack)
      else $error("autofeed not raised after capture");

   property p_tc_stop;
      @(posedge core_clk) disable iff (!resetn)
      dma_en && dma_tc && fifo_mode(mode) && !serv
      |=> serv && irq && !dma_request_pin;
   endproperty
   a_tc_stop: assert property (p_tc_stop)
      else $error("terminal count did not stop DMA");

   property p_no_drive;
      @(posedge core_clk) disable iff (!resetn)
      mode == MODE_ECP && !ackrev_s |=> pd_oe_n;
   endproperty
   a_no_drive: assert property (p_no_drive)
      else $error("data lines driven without permission");

   property p_floppy;
      @(posedge core_clk) disable iff (!resetn)
      external_floppy_mode |=> motor_b_output && drive_select_b_output;
   endproperty
   a_floppy: assert property (p_floppy)
      else $error("floppy B lines not forced inactive");
endmodule
`default_nettype wire

//--- logic/ecp_pkg.sv
// Constants, modes and state types of the parallel port engine.
//
// Overview of operation
// - Strobe falls to clock byte, waits on Busy.
// - Reverse: nAck means data valid, nAutoFd answers.
// - Reverse PeriphAck high data, low command.
// - Forward HostAck high data, low command.
// - Drive data lines only when nAckReverse permits.
// - nReverseRequest low selects reverse direction.
// - Falling nFault raises error interrupt in forward.
// - nSelectIn held deasserted in ECP mode.
// - Address port sends command, data port sends data.
// - Leave 000/001 freely; otherwise return only there.
// - Direction changes only in mode 001.
// - Automatic handshake only in modes 010 and 011.
// - Run length: count command then data, no compression.
// - FIFO cleared by reset, used in 010/011/110 only.
// - Service threshold comes from configuration field.
// - DMA moves FIFO bytes, requested on request pin.
// - Terminal count interrupts, sets flag, stops DMA.
// - Data port at 400H, address port at 000H.
// - Programmed I/O service requested by interrupt line.
// - Floppy mode: force B lines off, OR status.
// - Mode field in control bits seven to five.
package ecp_pkg;
   localparam int          FIFO_DEPTH    = 16;
   localparam int          FIFO_AW       = 4;
   localparam int          FIFO_W        = 9;
   localparam logic [2:0]  MODE_STD      = 3'h0;
   localparam logic [2:0]  MODE_PS2      = 3'h1;
   localparam logic [2:0]  MODE_COMPAT_FIFO_PORT    = 3'h2;
   localparam logic [2:0]  MODE_ECP      = 3'h3;
   localparam logic [2:0]  MODE_TEST     = 3'h6;
   localparam logic [2:0]  MODE_CONFIG   = 3'h7;
   localparam logic [10:0] OFF_ADDR_FIFO = 11'h000;
   localparam logic [10:0] OFF_DATA_FIFO = 11'h400;
   localparam int          ECR_MODE_LO   = 5;
   localparam int          ECR_NERR      = 4;
   localparam int          ECR_DMA       = 3;
   localparam int          ECR_SERV      = 2;
   localparam logic [2:0]  ECR_RST_MODE  = 3'h0;
   localparam logic [2:0]  STATUS_ONES   = 3'h7;
   localparam logic [12:0] PIN_SYNC_RST  = 13'h1FFF;
   typedef enum logic [1:0] {FWD_IDLE, FWD_SETUP, FWD_STROBE, FWD_HOLD}
      ecp_fwd_t;
   typedef enum logic [0:0] {REV_READY, REV_RELEASE} ecp_rev_t;
endpackage

//--- logic/ecp_fifo_mem.sv
// Storage of the shared byte FIFO with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module ecp_fifo_mem #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             core_clk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Write port; contents need no reset, the pointers guard them.
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Read with write bypass so a byte pushed into an empty FIFO is
   // seen at once instead of one cycle late.
   always_ff @(posedge core_clk) begin
      if (we && waddr == raddr) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

//--- tb/ecp_periph_model.sv
// Behavioural peripheral on the far side of the parallel cable.
`timescale 1ns/1ps
`default_nettype none
module ecp_periph_model #(
   parameter logic [8:0] REV0 = 9'h012,
   parameter logic [8:0] REV1 = 9'h19C
) (
   input  wire logic       core_clk,
   input  wire logic       strobe_n,
   input  wire logic       autofeed_n,
   input  wire logic       reverse_request_n,
   input  wire logic [7:0] pd_out,
   output logic            ack_n,
   output logic            busy,
   output logic            ack_reverse_n,
   output logic      [7:0] pd_in
);
   logic [8:0] cap [4];
   int         cap_cnt = 0;
   int         rev_i = 0;
   // One process plays both directions; every wait is bounded so that a
   // stuck host cannot hang the model itself.
   initial begin
      int k;
      {ack_n, ack_reverse_n} = 2'b11;
      busy = 1'b0;
      pd_in = 8'h00;
      forever begin
         @(posedge core_clk) #1;
         if (reverse_request_n && !strobe_n) begin
            cap[cap_cnt[1:0]] = {autofeed_n, pd_out};
            cap_cnt++;
            busy = 1'b1;
            for (k = 0; k < 50 && !strobe_n; k++) @(posedge core_clk) #1;
            busy = 1'b0;
         end else if (reverse_request_n != ack_reverse_n) begin
            repeat (2) @(posedge core_clk) #1;
            busy = 1'b0;
            ack_reverse_n = reverse_request_n;
         end else if (!ack_reverse_n && !autofeed_n && rev_i < 2) begin
            {busy, pd_in} = (rev_i == 0) ? REV0 : REV1;
            @(posedge core_clk) #1;
            ack_n = 1'b0;
            for (k = 0; k < 50 && !autofeed_n; k++) @(posedge core_clk) #1;
            ack_n = 1'b1;
            // Released data lines show the inverse, not a stale match.
            pd_in = ~pd_in;
            rev_i++;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/ecp_port_test.sv
// Self-checking bench for the parallel port engine.
`timescale 1ns/1ps
`default_nettype none
module ecp_port_test;
   import ecp_pkg::*;
   localparam logic [8:0] REV0 = 9'h012;
   localparam logic [8:0] REV1 = 9'h19C;
   logic        core_clk, resetn, host_wr, host_rd, ecr_wr, dir_wr, dir_wdata;
   logic        host_rd_cmd, host_rd_valid, direction, dma_request_pin, irq;
   logic        sw_strobe, sw_autofd, sw_init, sw_selectin, dma_ack, dma_tc;
   logic        strobe_n, autofeed_n, reverse_request_n, select_in_n, pd_oe_n;
   logic        ack_n, busy, ack_reverse_n, online, fault_n;
   logic        external_floppy_mode, motor_b_n_in, drive_select_b_n_in;
   logic        motor_b_output, drive_select_b_output;
   logic [10:0] host_addr;
   logic [7:0]  host_wdata, host_rdata, ecr_wdata, ecr_rdata, status_rdata;
   logic [7:0]  sw_data, dma_wdata, pd_in, pd_out;
   logic [3:0]  fifo_threshold;
   logic [4:0]  fdc_status_in, fdc_status_out;
   int          n_errors = 0, n_tests = 0, n_irq = 0, n0, i;
   logic [7:0]  row_ecr [5] = '{8'h64, 8'h44, 8'h24, 8'hC4, 8'h04};
   logic [2:0]  row_mode [5] = '{3'h3, 3'h3, 3'h1, 3'h6, 3'h0};

   ecp_port u_ecp_port (.*);
   ecp_periph_model #(.REV0(REV0), .REV1(REV1)) u_ecp_periph_model (.*);

   // Free-running core clock.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Interrupt pulses last one cycle, so they are counted as they pass.
   always @(posedge core_clk) begin
      if (irq === 1'b1) n_irq++;
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [9:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic set_ecr(input logic [7:0] v);
      ecr_wdata = v;
      ecr_wr = 1'b1;
      tick();
      ecr_wr = 1'b0;
      tick(3);
   endtask

   task automatic set_dir(input logic d);
      dir_wdata = d;
      dir_wr = 1'b1;
      tick();
      dir_wr = 1'b0;
      tick(2);
   endtask

   task automatic hwr(input logic [10:0] a, input logic [7:0] d);
      {host_addr, host_wdata} = {a, d};
      host_wr = 1'b1;
      tick();
      host_wr = 1'b0;
      tick();
   endtask

   // Reads one byte; the expected tag is the inverse of the line level.
   task automatic hrd(input string name, input logic [8:0] exp);
      host_addr = OFF_DATA_FIFO;
      host_rd = 1'b1;
      tick();
      host_rd = 1'b0;
      chk(name, {1'b1, ~exp[8], exp[7:0]},
          {host_rd_valid, host_rd_cmd, host_rdata});
      tick();
   endtask

   initial begin
      {resetn, host_wr, host_rd, ecr_wr, dir_wr, dir_wdata} = '0;
      {dma_ack, dma_tc, sw_strobe, sw_autofd, sw_selectin} = '0;
      {sw_init, online, fault_n, motor_b_n_in, drive_select_b_n_in} = '1;
      {external_floppy_mode, host_addr, host_wdata, ecr_wdata} = '0;
      {dma_wdata, sw_data, fifo_threshold, fdc_status_in} = 25'h05A811;
      tick(10);
      chk("reset pins", 10'h01F, {strobe_n, autofeed_n, reverse_request_n,
          select_in_n, pd_oe_n});
      resetn = 1'b1;
      tick(2);
      chk("reset ecr", 10'h001, ecr_rdata);
      $display("test reset done");
      // Mode table; the flag bit is preset so threshold events stay quiet.
      for (i = 0; i < 5; i++) begin
         set_ecr(row_ecr[i]);
         chk("mode", row_mode[i], ecr_rdata[7:5]);
      end
      $display("test modes done");
      set_ecr(8'h24);
      set_dir(1'b0);
      set_ecr(8'h64);
      set_dir(1'b1);
      chk("dir locked", 0, direction);
      hwr(OFF_ADDR_FIFO, 8'h05);
      hwr(OFF_DATA_FIFO, 8'hA5);
      for (i = 0; i < 300 && u_ecp_periph_model.cap_cnt < 2; i++) tick();
      chk("fwd count", 2, u_ecp_periph_model.cap_cnt);
      if (i >= 300) stop_test();
      chk("fwd cmd", 10'h005, u_ecp_periph_model.cap[0]);
      chk("fwd data", 10'h1A5, u_ecp_periph_model.cap[1]);
      chk("ecp pins", 2'b11, {select_in_n, reverse_request_n});
      n0 = n_irq;
      fault_n = 1'b0;
      tick(6);
      chk("fault irq", n0 + 1, n_irq);
      chk("status", 10'h0F7, status_rdata);
      fault_n = 1'b1;
      $display("test forward done");
      set_ecr(8'h24);
      set_ecr(8'h44);
      hwr(OFF_ADDR_FIFO, 8'h77);
      hwr(OFF_DATA_FIFO, 8'h5A);
      for (i = 0; i < 300 && u_ecp_periph_model.cap_cnt < 3; i++) tick();
      tick(30);
      chk("compat_fifo_port count", 3, u_ecp_periph_model.cap_cnt);
      if (i >= 300) stop_test();
      chk("compat_fifo_port data", 10'h15A, u_ecp_periph_model.cap[2]);
      $display("test compat fifo done");
      set_ecr(8'h24);
      set_dir(1'b1);
      chk("dir set", 1, direction);
      set_ecr(8'h64);
      for (i = 0; i < 300 && u_ecp_periph_model.rev_i < 2; i++) tick();
      chk("rev count", 2, u_ecp_periph_model.rev_i);
      if (i >= 300) stop_test();
      chk("rev pins", 2'b01, {reverse_request_n, pd_oe_n});
      hrd("rev cmd", REV0);
      hrd("rev data", REV1);
      $display("test reverse done");
      set_ecr(8'h24);
      set_dir(1'b0);
      n0 = n_irq;
      set_ecr(8'hC8);
      chk("dma req", 1, dma_request_pin);
      dma_wdata = 8'h3C;
      dma_ack = 1'b1;
      tick();
      {dma_ack, dma_tc} = 2'b01;
      tick();
      dma_tc = 1'b0;
      tick(3);
      chk("tc flag", 2'b01, {dma_request_pin, ecr_rdata[ECR_SERV]});
      chk("tc irq", n0 + 1, n_irq);
      hrd("dma byte", 9'h13C);
      fifo_threshold = 4'h4;
      for (i = 0; i < 17; i++) hwr(OFF_DATA_FIFO, i[7:0]);
      chk("fifo full", 10'h002, ecr_rdata[1:0]);
      n0 = n_irq;
      set_ecr(8'hC0);
      chk("pio quiet", n0, n_irq);
      for (i = 0; i < 4; i++) hrd("fifo byte", {1'b1, i[7:0]});
      tick(2);
      chk("pio irq", n0 + 1, n_irq);
      chk("pio req", 0, dma_request_pin);
      $display("test service done");
      {external_floppy_mode, motor_b_n_in, drive_select_b_n_in} = 3'b100;
      tick(4);
      chk("floppy b", 2'b11, {motor_b_output, drive_select_b_output});
      chk("floppy st", fdc_status_in | pd_in[4:0], fdc_status_out);
      external_floppy_mode = 1'b0;
      tick(2);
      chk("floppy off", 2'b00,
          {motor_b_output, drive_select_b_output});
      $display("test floppy done");
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(2);
      chk("reset again", 10'h001, ecr_rdata);
      $display("test reset again done");
      stop_test();
   end
endmodule
`default_nettype wire
